// ===== spm_protection.sv
// System protection monitors: watchdog, halt monitor, bus monitor, periodic interrupt control.
// Assumes a 125 MHz clock, synchronous active-high reset and an Avalon-MM master.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Protection control register takes only the first write after each reset.
// - Only the low byte of protection control exists; upper byte reads zero.
// - Watchdog runs only while its enable bit is one; enable resets to one.
// - Prescale bit set divides the watchdog clock by 512 before counting.
// - Prescale bit resets to the inverse of the sampled clock mode pin.
// - Divide ratio from prescale and timing field: 2^9..2^15 or 2^18..2^24.
// - Crystal reference counts reference periods; fast reference first divided by 128.
// - With an external system clock the ratio counts system clock periods.
// - Halt monitor acts only while its enable bit is one; resets to zero.
// - External bus cycles are monitored only while the bus monitor enable is one.
// - Bus time-out 64, 32, 16 or 8 clocks by timing field; resets 00.
// - Periodic control bits 10..0 read and write freely; bits 15..11 read zero.
// - Periodic request level sets interrupt priority; zero suppresses periodic interrupts.
// - On acknowledge, the vector field is supplied; it resets to 0x0f.
// - A watchdog reset is recorded in the reset status when leaving reset.
module spm_protection #(
   parameter int unsigned HOLD_CYCLES = spm_pkg::RST_HOLD_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic power_on,
   // Avalon-MM register port
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pins and straps
   input wire logic clock_mode_pin,
   input wire logic crystal_input_pin,
   input wire logic ext_clock_strap,
   input wire logic fast_ref_strap,
   // Processor and external bus
   input wire logic cpu_halted,
   input wire logic ext_cycle,
   input wire logic ext_ack,
   output logic bus_error,
   // Periodic timer interrupt
   input wire logic periodic_timer_tick,
   input wire logic periodic_iack,
   output logic [2:0] periodic_irq_level,
   output logic [7:0] periodic_vector,
   output logic periodic_vector_valid,
   // System reset and event interrupt
   output logic system_reset,
   output logic irq
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   localparam int unsigned NPIN = 4;
   localparam int unsigned PIN_MODE = 0;
   localparam int unsigned PIN_XTAL = 1;
   localparam int unsigned PIN_EXT = 2;
   localparam int unsigned PIN_FAST = 3;
   wire [NPIN-1:0] pin_raw = {fast_ref_strap, ext_clock_strap, crystal_input_pin, clock_mode_pin};
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;
   logic xtal_prev_q;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            sync1_q[gi] <= pin_raw[gi];
            sync2_q[gi] <= sync1_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      xtal_prev_q <= sync2_q[PIN_XTAL];
   end

   wire ref_tick = sync2_q[PIN_XTAL] & ~xtal_prev_q;

   // ==========================================================
   // Avalon-MM slave
   // ==========================================================
   logic waitrequest_q;
   logic [31:0] readdata_q;
   logic [31:0] read_word;
   wire req = read | write;
   wire take = req & ~waitrequest_q;
   wire [5:0] idx = address[7:2];
   wire wr_lo = take & write & byteenable[0];
   wire wr_hi = take & write & byteenable[1];

   function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_idx);
      hit = (a == reg_idx);
   endfunction

   // Every access is answered one cycle after it is seen, mapped or not.
   always_ff @(posedge clock) begin
      if (reset) begin
         waitrequest_q <= 1'b1;
         readdata_q <= 32'h0000_0000;
      end else begin
         waitrequest_q <= ~(req & waitrequest_q);
         if (req & waitrequest_q) begin
            readdata_q <= read_word;
         end
      end
   end

   // ==========================================================
   // Protection control
   // ==========================================================
   logic [7:0] prot_q;
   logic prot_written_q;
   wire prot_wr = wr_lo & hit(idx, spm_pkg::IDX_PROTECTION) & ~prot_written_q;

   always_ff @(posedge clock) begin
      if (reset) begin
         prot_q <= spm_pkg::PROT_RESET;
         // The prescale bit takes the complement of the synchronised mode strap.
         prot_q[spm_pkg::PROT_PRESCALE] <= ~sync2_q[PIN_MODE];
         prot_written_q <= 1'b0;
      end else if (prot_wr) begin
         prot_q <= writedata[7:0];
         prot_written_q <= 1'b1;
      end
   end

   wire wdog_en = prot_q[spm_pkg::PROT_WDOG_EN];
   wire halt_en = prot_q[spm_pkg::PROT_HALT_EN];
   wire bus_en = prot_q[spm_pkg::PROT_BUS_EN];
   wire [1:0] bmt = prot_q[spm_pkg::PROT_BMT_HI:spm_pkg::PROT_BMT_LO];

   // ==========================================================
   // Periodic interrupt control
   // ==========================================================
   logic [10:0] pic_q;
   wire pic_hit = take & write & hit(idx, spm_pkg::IDX_PERIODIC);

   always_ff @(posedge clock) begin
      if (reset) begin
         pic_q <= spm_pkg::PIC_RESET;
      end else if (pic_hit) begin
         if (byteenable[0]) begin
            pic_q[7:0] <= writedata[7:0];
         end
         if (byteenable[1]) begin
            pic_q[10:8] <= writedata[10:8];
         end
      end
   end

   wire [2:0] pic_level = pic_q[spm_pkg::PIC_LVL_HI:spm_pkg::PIC_LVL_LO];
   wire [7:0] pic_vector = pic_q[spm_pkg::PIC_VEC_HI:spm_pkg::PIC_VEC_LO];

   logic pit_pending_q;
   logic [2:0] pit_level_q;
   logic [7:0] pit_vector_q;
   logic pit_vector_valid_q;
   wire pit_set = periodic_timer_tick & (pic_level != spm_pkg::PIC_LVL_OFF);
   wire pit_ack = periodic_iack & pit_pending_q;

   // A new tick in the acknowledge cycle keeps the request pending.
   always_ff @(posedge clock) begin
      if (reset) begin
         pit_pending_q <= 1'b0;
         pit_level_q <= spm_pkg::PIC_LVL_OFF;
         pit_vector_q <= 8'h00;
         pit_vector_valid_q <= 1'b0;
      end else begin
         pit_pending_q <= pit_set | (pit_pending_q & ~pit_ack & (pic_level != spm_pkg::PIC_LVL_OFF));
         pit_level_q <= (pit_set | (pit_pending_q & ~pit_ack)) ? pic_level : spm_pkg::PIC_LVL_OFF;
         pit_vector_valid_q <= pit_ack;
         if (pit_ack) begin
            pit_vector_q <= pic_vector;
         end
      end
   end

   // ==========================================================
   // Watchdog service and timer
   // ==========================================================
   logic armed_q;
   wire svc_wr = wr_lo & hit(idx, spm_pkg::IDX_SERVICE);
   wire svc_arm = svc_wr & (writedata[7:0] == spm_pkg::SERVICE_ARM);
   wire svc_fire = svc_wr & armed_q & (writedata[7:0] == spm_pkg::SERVICE_FIRE);

   // Other writes between the two keys leave the sequence armed.
   always_ff @(posedge clock) begin
      if (reset | svc_fire) begin
         armed_q <= 1'b0;
      end else if (svc_arm) begin
         armed_q <= 1'b1;
      end
   end

   spm_wdog_if wd_bus();
   assign wd_bus.enable = wdog_en;
   assign wd_bus.prescale = prot_q[spm_pkg::PROT_PRESCALE];
   assign wd_bus.timing = prot_q[spm_pkg::PROT_WT_HI:spm_pkg::PROT_WT_LO];
   assign wd_bus.ext_clock = sync2_q[PIN_EXT];
   assign wd_bus.fast_ref = sync2_q[PIN_FAST];
   assign wd_bus.ref_tick = ref_tick;
   assign wd_bus.service = svc_fire;

   spm_wdog_timer u_timer (
      .clock(clock),
      .reset(reset),
      .wd(wd_bus.timer)
   );

   // ==========================================================
   // Bus monitor
   // ==========================================================
   logic [6:0] bm_cnt_q;
   logic bm_done_q;
   logic bus_error_q;
   wire bm_active = bus_en & ext_cycle & ~ext_ack & ~bm_done_q;
   wire [6:0] bm_limit = spm_pkg::BUSMON_BASE >> bmt;
   wire bm_timeout = bm_active & (bm_cnt_q == bm_limit - 7'h01);

   always_ff @(posedge clock) begin
      if (reset | ~bm_active) begin
         bm_cnt_q <= 7'h00;
      end else begin
         bm_cnt_q <= bm_cnt_q + 7'h01;
      end
   end

   // One error per cycle; the flag drops when the master ends the cycle.
   always_ff @(posedge clock) begin
      if (reset | ~ext_cycle) begin
         bm_done_q <= 1'b0;
         bus_error_q <= 1'b0;
      end else begin
         bus_error_q <= bm_timeout;
         if (bm_timeout) begin
            bm_done_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // System reset sequencer and cause recording
   // ==========================================================
   spm_pkg::spm_rst_state_t rst_state_q;
   logic [15:0] hold_q;
   logic sys_reset_q;
   wire wdog_trip = wd_bus.expired & wdog_en;
   wire halt_trip = halt_en & cpu_halted;
   wire trip = (wdog_trip | halt_trip) & (rst_state_q == spm_pkg::SPM_RUN);

   always_ff @(posedge clock) begin
      if (reset) begin
         rst_state_q <= spm_pkg::SPM_RUN;
         hold_q <= 16'h0000;
         sys_reset_q <= 1'b0;
      end else begin
         case (rst_state_q)
            spm_pkg::SPM_RUN: begin
               if (trip) begin
                  rst_state_q <= spm_pkg::SPM_HOLD;
                  hold_q <= 16'(HOLD_CYCLES - 1);
                  sys_reset_q <= 1'b1;
               end
            end
            spm_pkg::SPM_HOLD: begin
               if (hold_q == 16'h0000) begin
                  rst_state_q <= spm_pkg::SPM_RUN;
                  sys_reset_q <= 1'b0;
               end else begin
                  hold_q <= hold_q - 16'h0001;
               end
            end
            default: begin
               rst_state_q <= spm_pkg::SPM_RUN;
               sys_reset_q <= 1'b0;
            end
         endcase
      end
   end

   // Causes survive the block reset they provoke; power-on clears the watchdog and halt causes, and leaving reset clears all once copied into the status.
   logic cause_wdog_q;
   logic cause_halt_q;
   logic cause_pow_q;
   logic in_reset_q;
   logic [7:0] rstat_q;
   wire leaving = in_reset_q & ~reset;

   always_ff @(posedge clock) begin
      in_reset_q <= reset | power_on;
      if (power_on) begin
         cause_wdog_q <= 1'b0;
         cause_halt_q <= 1'b0;
         cause_pow_q <= 1'b1;
         rstat_q <= 8'h00;
      end else if (leaving) begin
         rstat_q <= 8'h00;
         rstat_q[spm_pkg::RST_SW] <= cause_wdog_q;
         rstat_q[spm_pkg::RST_HALT] <= cause_halt_q;
         rstat_q[spm_pkg::RST_POW] <= cause_pow_q;
         rstat_q[spm_pkg::RST_EXT] <= ~(cause_wdog_q | cause_halt_q | cause_pow_q);
         cause_wdog_q <= 1'b0;
         cause_halt_q <= 1'b0;
         cause_pow_q <= 1'b0;
      end else if (trip) begin
         cause_wdog_q <= wdog_trip;
         cause_halt_q <= halt_trip;
      end
   end

   // ==========================================================
   // Event status, enable and interrupt
   // ==========================================================
   logic [spm_pkg::EV_W-1:0] ev_status_q;
   logic [spm_pkg::EV_W-1:0] ev_enable_q;
   logic irq_q;
   wire [spm_pkg::EV_W-1:0] ev_set = {bm_timeout, halt_trip & trip, wdog_trip & trip};
   wire [spm_pkg::EV_W-1:0] ev_clr = (wr_lo & hit(idx, spm_pkg::IDX_EVENT_CLEAR)) ?
                                     writedata[spm_pkg::EV_W-1:0] : '0;

   // A set in the clearing cycle wins.
   always_ff @(posedge clock) begin
      if (reset) begin
         ev_status_q <= '0;
         ev_enable_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
         if (wr_lo & hit(idx, spm_pkg::IDX_EVENT_ENABLE)) begin
            ev_enable_q <= writedata[spm_pkg::EV_W-1:0];
         end
         irq_q <= |(((ev_status_q & ~ev_clr) | ev_set) & ev_enable_q);
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   always_comb begin
      read_word = 32'h0000_0000;
      case (idx)
         spm_pkg::IDX_PROTECTION: read_word[7:0] = prot_q;
         spm_pkg::IDX_PERIODIC: read_word[10:0] = pic_q;
         spm_pkg::IDX_RESET_STATUS: read_word[7:0] = rstat_q;
         spm_pkg::IDX_EVENT_STATUS: read_word[spm_pkg::EV_W-1:0] = ev_status_q;
         spm_pkg::IDX_EVENT_ENABLE: read_word[spm_pkg::EV_W-1:0] = ev_enable_q;
         default: read_word = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign bus_error = bus_error_q;
   assign periodic_irq_level = pit_level_q;
   assign periodic_vector = pit_vector_q;
   assign periodic_vector_valid = pit_vector_valid_q;
   assign system_reset = sys_reset_q;
   assign irq = irq_q;

endmodule

// ===== spm_pkg.sv
// Shared constants and types for the system protection monitors.
// Assumes a single 125 MHz clock and a 32-bit Avalon-MM register port.
package spm_pkg;

   // ==========================================================
   // Register map: word indices, byte address is four times the index
   // ==========================================================
   localparam int unsigned IDX_W = 6;
   localparam logic [5:0] IDX_RESET_STATUS = 6'h06;
   localparam logic [5:0] IDX_PROTECTION = 6'h20;
   localparam logic [5:0] IDX_PERIODIC = 6'h22;
   localparam logic [5:0] IDX_SERVICE = 6'h26;
   localparam logic [5:0] IDX_EVENT_STATUS = 6'h30;
   localparam logic [5:0] IDX_EVENT_ENABLE = 6'h31;
   localparam logic [5:0] IDX_EVENT_CLEAR = 6'h32;

   // ==========================================================
   // Protection control fields
   // ==========================================================
   localparam int unsigned PROT_WDOG_EN = 7;
   localparam int unsigned PROT_PRESCALE = 6;
   localparam int unsigned PROT_WT_HI = 5;
   localparam int unsigned PROT_WT_LO = 4;
   localparam int unsigned PROT_HALT_EN = 3;
   localparam int unsigned PROT_BUS_EN = 2;
   localparam int unsigned PROT_BMT_HI = 1;
   localparam int unsigned PROT_BMT_LO = 0;
   localparam logic [7:0] PROT_RESET = 8'h80;

   // ==========================================================
   // Periodic interrupt control fields
   // ==========================================================
   localparam int unsigned PIC_W = 11;
   localparam int unsigned PIC_LVL_HI = 10;
   localparam int unsigned PIC_LVL_LO = 8;
   localparam int unsigned PIC_VEC_HI = 7;
   localparam int unsigned PIC_VEC_LO = 0;
   localparam logic [10:0] PIC_RESET = 11'h00f;
   localparam logic [2:0] PIC_LVL_OFF = 3'h0;

   // ==========================================================
   // Service sequence, reset status and event bits
   // ==========================================================
   localparam logic [7:0] SERVICE_ARM = 8'h55;
   localparam logic [7:0] SERVICE_FIRE = 8'haa;
   localparam int unsigned RST_EXT = 7;
   localparam int unsigned RST_POW = 6;
   localparam int unsigned RST_SW = 5;
   localparam int unsigned RST_HALT = 4;
   localparam int unsigned EV_W = 3;
   localparam int unsigned EV_WDOG = 0;
   localparam int unsigned EV_HALT = 1;
   localparam int unsigned EV_BUS = 2;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned FAST_REF_DIV = 128;
   localparam int unsigned WDOG_PRESCALE = 512;
   localparam int unsigned RATIO_BASE_LOG2 = 9;
   localparam int unsigned RATIO_STEP_LOG2 = 2;
   localparam int unsigned RATIO_CNT_W = 16;
   localparam logic [6:0] BUSMON_BASE = 7'h40;
   localparam int unsigned RST_HOLD_CYCLES = 16;

   typedef enum logic {SPM_RUN, SPM_HOLD} spm_rst_state_t;

endpackage

// ===== spm_wdog_if.sv
// Carries the watchdog settings and events between the control block and the timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface spm_wdog_if;
   logic enable;
   logic prescale;
   logic [1:0] timing;
   logic ext_clock;
   logic fast_ref;
   logic ref_tick;
   logic service;
   logic expired;

   modport ctrl (output enable, output prescale, output timing, output ext_clock, output fast_ref,
                 output ref_tick, output service, input expired);
   modport timer (input enable, input prescale, input timing, input ext_clock, input fast_ref,
                  input ref_tick, input service, output expired);
endinterface

// ===== spm_wdog_timer.sv
// Watchdog counting chain: reference divider, prescaler and ratio counter.
// Assumes ref_tick is already a one-cycle pulse on the system clock.
`timescale 1ns/1ns
module spm_wdog_timer (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Watchdog settings and events
   spm_wdog_if.timer wd
);

   // ==========================================================
   // Tick chain
   // ==========================================================
   logic [6:0] ref_div_q;
   logic [8:0] pre_q;
   logic [spm_pkg::RATIO_CNT_W-1:0] cnt_q;
   logic expired_q;
   wire clear_all = reset | wd.service | ~wd.enable;
   wire ref_wrap = wd.ref_tick & (ref_div_q == 7'(spm_pkg::FAST_REF_DIV - 1));
   // With an external system clock every cycle counts, whatever the reference.
   wire base_tick = wd.ext_clock | (wd.fast_ref ? ref_wrap : wd.ref_tick);
   wire pre_wrap = base_tick & (pre_q == 9'(spm_pkg::WDOG_PRESCALE - 1));
   wire count_tick = wd.prescale ? pre_wrap : base_tick;
   localparam int unsigned RATIO_CNT_W = spm_pkg::RATIO_CNT_W;
   wire [4:0] ratio_log2 = 5'(spm_pkg::RATIO_BASE_LOG2) + 5'({wd.timing, 1'b0});
   wire [spm_pkg::RATIO_CNT_W-1:0] limit = RATIO_CNT_W'((17'h1 << ratio_log2) - 17'h1);
   wire terminal = count_tick & (cnt_q == limit);
   always_ff @(posedge clock) begin
      if (clear_all | ~wd.fast_ref) begin
         ref_div_q <= 7'h00;
      end else if (wd.ref_tick) begin
         ref_div_q <= ref_wrap ? 7'h00 : ref_div_q + 7'h01;
      end
   end
   always_ff @(posedge clock) begin
      if (clear_all | ~wd.prescale) begin
         pre_q <= 9'h000;
      end else if (base_tick) begin
         pre_q <= pre_wrap ? 9'h000 : pre_q + 9'h001;
      end
   end
   // Counting stops while disabled and restarts on service.
   always_ff @(posedge clock) begin
      if (clear_all) begin
         cnt_q <= '0;
         expired_q <= 1'b0;
      end else begin
         expired_q <= terminal;
         if (count_tick) begin
            cnt_q <= terminal ? '0 : cnt_q + RATIO_CNT_W'(1);
         end
      end
   end

   assign wd.expired = expired_q;

endmodule

// ===== spm_protection_props.sv
// Checker of the protection monitor ports: register handshake, bus error, periodic and reset outputs.
// Assumes a bench that keeps the Avalon-MM master rules and holds ext_cycle for a whole cycle.
`timescale 1ns/1ns
module spm_protection_props #(
   parameter int unsigned HOLD_CYCLES = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // External bus
   input wire logic ext_cycle,
   input wire logic ext_ack,
   input wire logic bus_error,
   // Periodic timer and system reset
   input wire logic periodic_timer_tick,
   input wire logic periodic_iack,
   input wire logic [2:0] periodic_irq_level,
   input wire logic periodic_vector_valid,
   input wire logic system_reset
);
   // =====================
   // Helper logic
   // =====================
   // A counter stands in for a long repetition, which the tools would unroll.
   logic [7:0] hold_q;
   wire [7:0] hold_d = system_reset ? hold_q + 8'h01 : 8'h00;
   always_ff @(posedge clock) begin
      hold_q <= reset ? 8'h00 : hold_d;
   end
   // =====================
   // Properties
   // =====================
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence s_req_open;
      (read || write) && waitrequest;
   endsequence
   sequence s_ack_alone;
      periodic_iack && !periodic_timer_tick;
   endsequence
   a_bus_answer_next: assert property (s_req_open |=> !waitrequest)
      else $error("no answer one cycle after a request");
   a_answer_one_cycle: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_ack_gives_vector: assert property (periodic_iack |=> periodic_vector_valid)
      else $error("no vector after acknowledge");
   a_valid_needs_ack: assert property (periodic_vector_valid |-> $past(periodic_iack))
      else $error("vector offered without acknowledge");
   a_ack_drops_level: assert property (s_ack_alone |=> periodic_irq_level == 3'h0)
      else $error("request level stayed after acknowledge");
   a_buserr_one_pulse: assert property (bus_error |=> !bus_error)
      else $error("bus error longer than one cycle");
   a_buserr_needs_cycle: assert property (bus_error |-> $past(ext_cycle) && !$past(ext_ack))
      else $error("bus error without an unanswered cycle");
   a_buserr_not_early: assert property (bus_error |-> $past(ext_cycle, 8))
      else $error("bus error before the shortest time-out");
   a_reset_hold_len: assert property ($fell(system_reset) |-> int'(hold_q) == HOLD_CYCLES)
      else $error("system reset held for a wrong time");
endmodule
bind spm_protection spm_protection_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
   .clock(clock), .reset(reset), .read(read), .write(write), .waitrequest(waitrequest), .ext_cycle(ext_cycle),
   .ext_ack(ext_ack), .bus_error(bus_error), .periodic_timer_tick(periodic_timer_tick),
   .periodic_iack(periodic_iack), .periodic_irq_level(periodic_irq_level),
   .periodic_vector_valid(periodic_vector_valid), .system_reset(system_reset));

// ===== spm_protection_tb.sv
// Bench for the protection monitors: registers, bus monitor, interrupt, periodic, watchdog and halt.
// Assumes the checker file is compiled alongside; one initial process drives every input except the clock and the tied pins.
`timescale 1ns/1ns
module spm_protection_tb;
   // =====================
   // Signals
   // =====================
   localparam logic [7:0] addr_rst = {spm_pkg::IDX_RESET_STATUS, 2'b00};
   localparam logic [7:0] addr_prot = {spm_pkg::IDX_PROTECTION, 2'b00};
   localparam logic [7:0] addr_pic = {spm_pkg::IDX_PERIODIC, 2'b00};
   localparam logic [7:0] addr_svc = {spm_pkg::IDX_SERVICE, 2'b00};
   localparam logic [7:0] addr_stat = {spm_pkg::IDX_EVENT_STATUS, 2'b00};
   localparam logic [7:0] addr_en = {spm_pkg::IDX_EVENT_ENABLE, 2'b00};
   localparam logic [7:0] addr_clr = {spm_pkg::IDX_EVENT_CLEAR, 2'b00};
   logic clock = 1'b0, reset = 1'b1, power_on = 1'b1, read = 1'b0, write = 1'b0, cpu_halted = 1'b0;
   logic ext_cycle = 1'b0, ext_ack = 1'b0, periodic_timer_tick = 1'b0, periodic_iack = 1'b0, clock_mode_pin = 1'b1;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic [2:0] periodic_irq_level;
   logic [7:0] periodic_vector;
   logic waitrequest, bus_error, periodic_vector_valid, system_reset, irq;
   int failures = 0;
   int n_tests = 0;
   int n;
   // Straps give a watchdog of 512 system clocks, short enough to run to expiry.
   spm_protection #(.HOLD_CYCLES(8)) DUT (
      .clock(clock), .reset(reset), .power_on(power_on), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
      .clock_mode_pin(clock_mode_pin), .crystal_input_pin(1'b0), .ext_clock_strap(1'b1), .fast_ref_strap(1'b0),
      .cpu_halted(cpu_halted), .ext_cycle(ext_cycle), .ext_ack(ext_ack), .bus_error(bus_error),
      .periodic_timer_tick(periodic_timer_tick), .periodic_iack(periodic_iack),
      .periodic_irq_level(periodic_irq_level), .periodic_vector(periodic_vector),
      .periodic_vector_valid(periodic_vector_valid), .system_reset(system_reset), .irq(irq));
   always #4 clock = ~clock;
   // =====================
   // Tasks
   // =====================
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      for (i = 0; i < 20 && waitrequest !== 1'b0; i++) begin
         @(posedge clock);
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (i == 20) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & mask, exp);
   endtask
   // The select code picks the awaited condition: bus error, reset rising, reset falling.
   task automatic waitfor(input int sel, input int lim, output int cnt);
      for (cnt = 0; cnt < lim; cnt++) begin
         @(posedge clock);
         if ((sel == 0 && bus_error === 1'b1) || (sel == 1 && system_reset === 1'b1)) break;
         if (sel == 2 && system_reset === 1'b0) break;
      end
      if (cnt == lim) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic pulse(input logic ack);
      @(posedge clock);
      periodic_iack <= ack;
      periodic_timer_tick <= !ack;
      @(posedge clock);
      periodic_iack <= 1'b0;
      periodic_timer_tick <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   // =====================
   // Scenarios
   // =====================
   initial begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      power_on <= 1'b0;
      rdc(addr_prot, 32'hffffffff, 32'h80);
      rdc(addr_pic, 32'hffffffff, 32'h00f);
      rdc(addr_rst, 32'hff, 32'h40);
      rdc(8'h10, 32'hffffffff, 32'h0);
      wr(addr_pic, 32'hffffffff);
      rdc(addr_pic, 32'hffffffff, 32'h7ff);
      wr(addr_prot, 32'hffff0087);
      wr(addr_prot, 32'h0);
      rdc(addr_prot, 32'hffffffff, 32'h87);
      wr(addr_svc, 32'h55);
      wr(addr_svc, 32'haa);
      wr(addr_en, 32'h7);
      ext_cycle <= 1'b1;
      repeat (4) @(posedge clock);
      ext_ack <= 1'b1;
      @(posedge clock);
      ext_cycle <= 1'b0;
      ext_ack <= 1'b0;
      repeat (3) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      ext_cycle <= 1'b1;
      waitfor(0, 100, n);
      ext_cycle <= 1'b0;
      chk(32'(n >= 7 && n <= 12), 32'h1);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h1);
      rdc(addr_stat, 32'hff, 32'h4);
      wr(addr_en, 32'h0);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      wr(addr_en, 32'h7);
      wr(addr_clr, 32'h4);
      rdc(addr_stat, 32'hff, 32'h0);
      chk({31'h0, irq}, 32'h0);
      cpu_halted <= 1'b1;
      wr(addr_pic, 32'h342);
      pulse(1'b0);
      chk({29'h0, periodic_irq_level}, 32'h3);
      pulse(1'b1);
      chk({24'h0, periodic_vector}, 32'h42);
      wr(addr_pic, 32'h042);
      pulse(1'b0);
      chk({29'h0, periodic_irq_level}, 32'h0);
      cpu_halted <= 1'b0;
      chk({31'h0, system_reset}, 32'h0);
      wr(addr_svc, 32'h55);
      wr(addr_svc, 32'haa);
      waitfor(1, 700, n);
      chk(32'(n >= 490 && n <= 530), 32'h1);
      waitfor(2, 50, n);
      reset <= 1'b1;
      clock_mode_pin <= 1'b0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      rdc(addr_rst, 32'h20, 32'h20);
      rdc(addr_prot, 32'hff, 32'hc0);
      wr(addr_prot, 32'h08);
      rdc(addr_prot, 32'hff, 32'h08);
      repeat (600) @(posedge clock);
      chk({31'h0, system_reset}, 32'h0);
      cpu_halted <= 1'b1;
      waitfor(1, 60, n);
      cpu_halted <= 1'b0;
      waitfor(2, 50, n);
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      rdc(addr_rst, 32'h10, 32'h10);
      end_of_test();
   end
endmodule
